// >>> didf_pkg.sv
// Package with constants and types for the digital input function dispatcher.
package didf_pkg;

  // Function selector codes handled by this block.
  localparam logic [5:0] FN_TORQUE_PROHIBIT = 6'h1D;
  localparam logic [5:0] FN_PULSE_INPUT = 6'h1E;
  localparam logic [5:0] FN_DC_BRAKE_NOW = 6'h20;
  localparam logic [5:0] FN_EXT_FAULT_NC = 6'h21;
  localparam logic [5:0] FN_FREQ_LOCK = 6'h22;
  localparam logic [5:0] FN_PID_REVERSE = 6'h23;
  localparam logic [5:0] FN_EXT_STOP_ONE = 6'h24;
  localparam logic [5:0] FN_CMD_SRC_TWO = 6'h25;
  localparam logic [5:0] FN_PID_INT_HOLD = 6'h26;
  localparam logic [5:0] FN_MAIN_PRESET = 6'h27;
  localparam logic [5:0] FN_AUX_PRESET = 6'h28;
  localparam logic [5:0] FN_MOTOR_SEL_ONE = 6'h29;
  localparam logic [5:0] FN_MOTOR_SEL_TWO = 6'h2A;
  localparam logic [5:0] FN_PID_SET_SWAP = 6'h2B;
  localparam logic [5:0] FN_USER_FAULT_ONE = 6'h2C;
  localparam logic [5:0] FN_USER_FAULT_TWO = 6'h2D;
  localparam logic [5:0] FN_MODE_SWAP = 6'h2E;
  localparam logic [5:0] FN_EMERGENCY_STOP = 6'h2F;
  localparam logic [5:0] FN_EXT_STOP_TWO = 6'h30;
  localparam logic [5:0] FN_DECEL_DC_BRAKE = 6'h31;
  localparam logic [5:0] FN_CLEAR_RUN_TIME = 6'h32;
  localparam logic [5:0] FN_LINE_MODE_SWAP = 6'h33;

  // Fault codes reported to the drive core.
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_EXTERNAL = 8'h0F;
  localparam logic [7:0] FAULT_USER_ONE = 8'h1B;
  localparam logic [7:0] FAULT_USER_TWO = 8'h1C;

  // Index of the pulse capable input (the fifth terminal, counted from zero).
  localparam int PULSE_INPUT_INDEX = 4;
  // Deceleration time group used by the second external stop (group four).
  localparam logic [1:0] DECEL_GROUP_FOUR = 2'h3;
  // Pid set selection mode value that hands the choice to a terminal.
  localparam logic [1:0] PID_SET_BY_TERMINAL = 2'h1;

  // Register map of the plain register port.
  localparam logic [7:0] ADDR_FUNC_BASE = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h11;
  localparam logic [7:0] ADDR_LEVELS = 8'h12;
  localparam logic [5:0] FUNC_RESET = 6'h00;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;

  // Config register field positions.
  localparam int CFG_CMD_SRC_LSB = 0;
  localparam int CFG_LINE_MODE_LSB = 2;
  localparam int CFG_PID_SEL_LSB = 4;
  localparam int CFG_DEFAULT_TORQUE = 6;
  localparam int CFG_PID_DIR = 7;
  localparam int CFG_RUN_EN_A = 8;
  localparam int CFG_RUN_EN_B = 9;

  // Command sources of the drive.
  typedef enum logic [1:0] {
    DIDF_SRC_PANEL = 2'h0,
    DIDF_SRC_TERMINAL = 2'h1,
    DIDF_SRC_COMM = 2'h2
  } didf_cmd_src_t;

  // Terminal command modes.
  typedef enum logic [1:0] {
    DIDF_TWO_LINE_ONE = 2'h0,
    DIDF_TWO_LINE_TWO = 2'h1,
    DIDF_THREE_LINE_ONE = 2'h2,
    DIDF_THREE_LINE_TWO = 2'h3
  } didf_line_mode_t;

  // Stop sequencer states.
  typedef enum logic [1:0] {
    DIDF_IDLE,
    DIDF_DECEL_TO_BRAKE,
    DIDF_DC_BRAKE
  } didf_brake_state_t;

endpackage : didf_pkg

// >>> didf_term_decode.sv
// Per-terminal decoder: one stored selector and one filtered level to a one-hot request set.
`timescale 1ns/1ps
module didf_term_decode
  import didf_pkg::*;
#(
  parameter int INDEX = 0
) (
  input wire logic [5:0] func_sel,
  input wire logic level,
  output logic [22:0] req
);

  // Bit k of the request vector stands for selector code 29 + k.
  function automatic logic [22:0] didf_onehot(input logic [5:0] code);
    logic [22:0] v;
    v = 23'h000000;
    if (code >= FN_TORQUE_PROHIBIT && code <= FN_LINE_MODE_SWAP) begin
      v[5'(code - FN_TORQUE_PROHIBIT)] = 1'b1;
    end
    return v;
  endfunction : didf_onehot

  // Pulse input counts only on the fifth terminal.
  logic pulse_ok;
  assign pulse_ok = (func_sel != FN_PULSE_INPUT) || (INDEX == PULSE_INPUT_INDEX);
  // An active terminal raises the request of its selected function.
  assign req = (level && pulse_ok) ? didf_onehot(func_sel) : 23'h000000;

endmodule : didf_term_decode

// >>> didf_dispatcher.sv
// Digital input function dispatcher for terminal functions 29 to 51.
//
// Operation
// - Torque-prohibit terminal forces speed control mode.
// - Pulse input works only on fifth terminal.
// - Immediate brake enters DC braking without deceleration.
// - NC external fault raises fault 15, stops.
// - Frequency-lock terminal ignores all frequency changes.
// - Reverse-PID terminal inverts configured PID direction.
// - External stop one acts only under panel.
// - Terminal source plus switch moves to communication.
// - PID integral pause freezes integral term only.
// - Preset frequency replaces main or auxiliary source.
// - Two motor-select terminals form a 2-bit code.
// - Codes map to motors one to four.
// - Terminal picks PID set when mode is one.
// - User faults raise 27 or 28, configured action.
// - Mode-swap terminal selects the non-default control mode.
// - Emergency stop fastest, current held at limit.
// - External stop two decelerates using time four.
// - Decel brake slows to brake frequency, then brakes.
// - Clear running time when enables allow it.
// - Two-line mode 1 swaps to three-line mode 1.
`timescale 1ns/1ps
module didf_dispatcher
  import didf_pkg::*;
#(
  parameter int NUM_TERMS = 10
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [NUM_TERMS-1:0] term_level,
  input wire logic at_brake_freq,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic speed_mode_force,
  output logic torque_mode_sel,
  output logic pulse_count_en,
  output logic dc_brake_req,
  output logic decel_to_brake_req,
  output logic [7:0] fault_code,
  output logic fault_user_action,
  output logic stop_req,
  output logic stop_fast_req,
  output logic current_limit_hold,
  output logic [1:0] decel_group_sel,
  output logic freq_change_block,
  output logic pid_direction_eff,
  output logic pid_integral_hold,
  output logic main_use_preset,
  output logic aux_use_preset,
  output logic [1:0] cmd_source_eff,
  output logic [1:0] motor_sel,
  output logic pid_set_two_sel,
  output logic run_time_clear,
  output logic [1:0] line_mode_eff
);

  // Stored selectors, one per terminal, and the configuration register.
  logic [5:0] func_q [NUM_TERMS];
  logic [15:0] config_q;
  logic [15:0] rdata_q;
  logic [22:0] req_vec [NUM_TERMS];
  logic [22:0] req_any;
  logic [22:0] req_prev_q;
  logic [22:0] req_rise;
  didf_brake_state_t brake_q;
  didf_brake_state_t brake_d;

  // Register write decode.
  wire wr_config = reg_wr && (reg_addr == ADDR_CONFIG);

  // Configuration fields.
  wire [1:0] cmd_source_cfg = config_q[CFG_CMD_SRC_LSB +: 2];
  wire [1:0] line_mode_cfg = config_q[CFG_LINE_MODE_LSB +: 2];
  wire [1:0] pid_set_select_mode = config_q[CFG_PID_SEL_LSB +: 2];
  wire default_control_mode = config_q[CFG_DEFAULT_TORQUE];
  wire pid_direction_setting = config_q[CFG_PID_DIR];
  wire running_time_enable_a = config_q[CFG_RUN_EN_A];
  wire running_time_enable_b = config_q[CFG_RUN_EN_B];

  // One decoder per terminal, and its selector register.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERMS; gi++) begin : g_term
      didf_term_decode #(.INDEX(gi)) u_dec (
        .func_sel(func_q[gi]),
        .level(term_level[gi]),
        .req(req_vec[gi])
      );
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          func_q[gi] <= FUNC_RESET;
        end else if (clk_en && reg_wr && reg_addr == ADDR_FUNC_BASE + 8'(gi)) begin
          func_q[gi] <= reg_wdata[5:0];
        end
      end
    end
  endgenerate

  // Any terminal carrying a function makes it active.
  always_comb begin
    req_any = 23'h000000;
    for (int i = 0; i < NUM_TERMS; i++) begin
      req_any = req_any | req_vec[i];
    end
  end

  // Rising edges of each function, for event style requests.
  assign req_rise = req_any & ~req_prev_q;

  // Function bit positions within the request vector.
  localparam int B_TQP = 0;
  localparam int B_PUL = 1;
  localparam int B_DCN = 3;
  localparam int B_EXF = 4;
  localparam int B_FRL = 5;
  localparam int B_PRV = 6;
  localparam int B_ST1 = 7;
  localparam int B_CS2 = 8;
  localparam int B_PIH = 9;
  localparam int B_MPR = 10;
  localparam int B_APR = 11;
  localparam int B_MS1 = 12;
  localparam int B_MS2 = 13;
  localparam int B_PSW = 14;
  localparam int B_UF1 = 15;
  localparam int B_UF2 = 16;
  localparam int B_MSW = 17;
  localparam int B_EST = 18;
  localparam int B_ST2 = 19;
  localparam int B_DDB = 20;
  localparam int B_CRT = 21;
  localparam int B_LMS = 22;

  // Control mode: prohibit beats the swap terminal.
  assign speed_mode_force = req_any[B_TQP];
  assign torque_mode_sel = !req_any[B_TQP] && (default_control_mode ^ req_any[B_MSW]);
  assign pulse_count_en = req_any[B_PUL];

  // Frequency and PID steering levels.
  assign freq_change_block = req_any[B_FRL];
  assign pid_direction_eff = pid_direction_setting ^ req_any[B_PRV];
  assign pid_integral_hold = req_any[B_PIH];
  assign main_use_preset = req_any[B_MPR];
  assign aux_use_preset = req_any[B_APR];
  assign pid_set_two_sel = (pid_set_select_mode == PID_SET_BY_TERMINAL) && req_any[B_PSW];

  // Motor group: terminal 2 is the high bit, so code 0..3 means motor 1..4.
  assign motor_sel = {req_any[B_MS2], req_any[B_MS1]};

  // Command source switchover from terminal to communication.
  assign cmd_source_eff = (cmd_source_cfg == DIDF_SRC_TERMINAL && req_any[B_CS2]) ?
                          DIDF_SRC_COMM : cmd_source_cfg;

  // Line mode switchover from two-line 1 to three-line 1.
  assign line_mode_eff = (line_mode_cfg == DIDF_TWO_LINE_ONE && req_any[B_LMS]) ?
                         DIDF_THREE_LINE_ONE : line_mode_cfg;

  // Stop requests; stop one is honoured only under panel control.
  wire stop_one = req_any[B_ST1] && (cmd_source_eff == DIDF_SRC_PANEL);
  wire stop_two = req_any[B_ST2];
  wire stop_emg = req_any[B_EST];
  wire ext_fault = req_any[B_EXF];
  assign stop_fast_req = stop_emg;
  assign current_limit_hold = stop_emg;

  // Stop sequencer: immediate brake skips the deceleration phase.
  always_comb begin
    brake_d = brake_q;
    unique case (brake_q)
      DIDF_IDLE: begin
        if (req_any[B_DCN]) begin
          brake_d = DIDF_DC_BRAKE;
        end else if (req_rise[B_DDB]) begin
          brake_d = DIDF_DECEL_TO_BRAKE;
        end
      end
      DIDF_DECEL_TO_BRAKE: begin
        if (req_any[B_DCN] || at_brake_freq) begin
          brake_d = DIDF_DC_BRAKE;
        end else if (!req_any[B_DDB]) begin
          brake_d = DIDF_IDLE;
        end
      end
      DIDF_DC_BRAKE: begin
        if (!req_any[B_DCN] && !req_any[B_DDB]) begin
          brake_d = DIDF_IDLE;
        end
      end
    endcase
  end

  assign dc_brake_req = (brake_q == DIDF_DC_BRAKE);
  assign decel_to_brake_req = (brake_q == DIDF_DECEL_TO_BRAKE);

  // Registered event and data outputs.
  logic [7:0] fault_q;
  logic fault_user_q;
  logic stop_q;
  logic [1:0] decel_q;
  logic clear_q;

  // Fault priority: external fault first, then user faults.
  wire [7:0] fault_d = ext_fault ? FAULT_EXTERNAL :
                       req_any[B_UF1] ? FAULT_USER_ONE :
                       req_any[B_UF2] ? FAULT_USER_TWO : FAULT_NONE;
  wire clear_d = req_rise[B_CRT] && running_time_enable_a && running_time_enable_b;

  // Sequential state: edges, fault, stop and sequencer.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      req_prev_q <= 23'h000000;
      brake_q <= DIDF_IDLE;
      fault_q <= FAULT_NONE;
      fault_user_q <= 1'b0;
      stop_q <= 1'b0;
      decel_q <= 2'h0;
      clear_q <= 1'b0;
    end else if (clk_en) begin
      req_prev_q <= req_any;
      brake_q <= brake_d;
      fault_q <= fault_d;
      fault_user_q <= !ext_fault && (req_any[B_UF1] || req_any[B_UF2]);
      stop_q <= stop_one || stop_two || stop_emg || ext_fault;
      decel_q <= stop_two ? DECEL_GROUP_FOUR : 2'h0;
      clear_q <= clear_d;
    end
  end

  assign fault_code = fault_q;
  assign fault_user_action = fault_user_q;
  assign stop_req = stop_q;
  assign decel_group_sel = decel_q;
  assign run_time_clear = clear_q;

  // Config write and read port; reads answer one cycle later.
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (reg_addr == ADDR_CONFIG) begin
      rd_mux = config_q;
    end else if (reg_addr == ADDR_STATUS) begin
      rd_mux = {fault_q, 4'h0, motor_sel, brake_q};
    end else if (reg_addr == ADDR_LEVELS) begin
      rd_mux = 16'(term_level);
    end else if (reg_addr < ADDR_FUNC_BASE + 8'(NUM_TERMS)) begin
      rd_mux = {10'h000, func_q[reg_addr[3:0]]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      config_q <= CONFIG_RESET;
      rdata_q <= 16'h0000;
    end else if (clk_en) begin
      if (wr_config) begin
        config_q <= reg_wdata;
      end
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end
  assign reg_rdata = rdata_q;

  // Checks next to the logic.
  stop_fault_a: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && ext_fault |=> fault_code == FAULT_EXTERNAL && stop_req)
    else $error("external fault not reported");
  brake_direct_a: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && req_any[B_DCN] |=> dc_brake_req)
    else $error("immediate brake not entered");
  speed_force_a: assert property (@(posedge core_clk) disable iff (!resetn)
    req_any[B_TQP] |-> !torque_mode_sel && speed_mode_force)
    else $error("torque mode while prohibited");
  stop_decel_a: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && stop_two |=> stop_req && decel_group_sel == DECEL_GROUP_FOUR)
    else $error("stop two wrong decel group");
  src_switch_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_source_cfg == DIDF_SRC_TERMINAL && req_any[B_CS2] |-> cmd_source_eff == DIDF_SRC_COMM)
    else $error("command source not switched");
  line_switch_a: assert property (@(posedge core_clk) disable iff (!resetn)
    line_mode_cfg == DIDF_TWO_LINE_ONE && req_any[B_LMS] |-> line_mode_eff == DIDF_THREE_LINE_ONE)
    else $error("line mode not switched");
  motor_code_a: assert property (@(posedge core_clk) disable iff (!resetn)
    req_any[B_MS2] && !req_any[B_MS1] |-> motor_sel == 2'h2)
    else $error("motor three code wrong");
  run_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    run_time_clear |-> $past(running_time_enable_a) && $past(running_time_enable_b))
    else $error("run time cleared while disabled");
  decel_brake_a: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && decel_to_brake_req && at_brake_freq |=> dc_brake_req)
    else $error("decel brake did not enter braking");

endmodule : didf_dispatcher

// >>> didf_switch_bank.sv
// Behavioural bank of external switches that drive the filtered terminal levels.
`timescale 1ns/1ps
module didf_switch_bank #(
  parameter int NUM_TERMS = 10
) (
  input wire logic core_clk,
  input wire logic [NUM_TERMS-1:0] want,
  output logic [NUM_TERMS-1:0] term_level
);
  // Contacts change only at a clock edge, so the core never sees a level move mid-cycle.
  always_ff @(posedge core_clk) begin
    term_level <= want;
  end
endmodule : didf_switch_bank

// >>> tb_digital_input_function_dispatcher.sv
// Self-checking testbench for the digital input function dispatcher.
`timescale 1ns/1ps
module tb_digital_input_function_dispatcher;
  import didf_pkg::*;
  typedef struct {logic [5:0] fn; int idx; logic [15:0] cfg; logic [31:0] exp;} didf_row_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic at_brake_freq = 1'b0;
  logic [9:0] sw_want = '0;
  logic [9:0] term_level;
  logic [7:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic speed_mode_force, torque_mode_sel, pulse_count_en, dc_brake_req, decel_to_brake_req;
  logic [7:0] fault_code;
  logic fault_user_action, stop_req, stop_fast_req, current_limit_hold, freq_change_block;
  logic pid_direction_eff, pid_integral_hold, main_use_preset, aux_use_preset;
  logic pid_set_two_sel, run_time_clear;
  logic [1:0] decel_group_sel, cmd_source_eff, motor_sel, line_mode_eff;
  logic [31:0] obs;
  int n_mismatch = 0;
  int checked = 0;
  int n_clr = 0;
  int cycles = 0;
  // Ordinary cases: selector, terminal, config, and the packed outputs with the terminal ON.
  didf_row_t rows [28] = '{
    '{6'h1D, 0, 16'h0040, 32'h00020000},
    '{6'h1E, 4, 16'h0000, 32'h00008000},
    '{6'h1E, 0, 16'h0000, 32'h00000000},
    '{6'h1F, 0, 16'h0000, 32'h00000000},
    '{6'h20, 0, 16'h0000, 32'h00040000},
    '{6'h21, 0, 16'h0000, 32'h03E00000},
    '{6'h22, 0, 16'h0000, 32'h00004000},
    '{6'h23, 0, 16'h0000, 32'h00002000},
    '{6'h23, 0, 16'h0080, 32'h00000000},
    '{6'h24, 0, 16'h0000, 32'h00200000},
    '{6'h24, 0, 16'h0001, 32'h00000008},
    '{6'h25, 0, 16'h0001, 32'h00000010},
    '{6'h25, 0, 16'h0000, 32'h00000000},
    '{6'h26, 0, 16'h0000, 32'h00001000},
    '{6'h27, 0, 16'h0000, 32'h00000800},
    '{6'h28, 0, 16'h0000, 32'h00000400},
    '{6'h29, 0, 16'h0000, 32'h00000020},
    '{6'h2A, 0, 16'h0000, 32'h00000040},
    '{6'h2B, 0, 16'h0010, 32'h00000080},
    '{6'h2B, 0, 16'h0000, 32'h00000000},
    '{6'h2C, 0, 16'h0000, 32'h06C00001},
    '{6'h2D, 0, 16'h0000, 32'h07000001},
    '{6'h2E, 0, 16'h0000, 32'h00010000},
    '{6'h2E, 0, 16'h0040, 32'h00000000},
    '{6'h2F, 0, 16'h0000, 32'h00200300},
    '{6'h30, 0, 16'h0001, 32'h00380008},
    '{6'h33, 0, 16'h0000, 32'h00000004},
    '{6'h33, 0, 16'h0004, 32'h00000002}
  };

  // Packs the request outputs into one word for table comparison.
  assign obs = {2'h0, fault_code, stop_req, decel_group_sel, dc_brake_req, speed_mode_force,
    torque_mode_sel, pulse_count_en, freq_change_block, pid_direction_eff, pid_integral_hold,
    main_use_preset, aux_use_preset, stop_fast_req, current_limit_hold, pid_set_two_sel,
    motor_sel, cmd_source_eff, line_mode_eff, fault_user_action};

  didf_switch_bank #(.NUM_TERMS(10)) u_switches (.core_clk, .want(sw_want), .term_level);

  didf_dispatcher #(.NUM_TERMS(10)) DUT (.core_clk, .resetn, .clk_en, .term_level,
    .at_brake_freq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .speed_mode_force,
    .torque_mode_sel, .pulse_count_en, .dc_brake_req, .decel_to_brake_req, .fault_code,
    .fault_user_action, .stop_req, .stop_fast_req, .current_limit_hold, .decel_group_sel,
    .freq_change_block, .pid_direction_eff, .pid_integral_hold, .main_use_preset,
    .aux_use_preset, .cmd_source_eff, .motor_sel, .pid_set_two_sel, .run_time_clear,
    .line_mode_eff);

  // Clock at 100 MHz.
  always #5 core_clk = ~core_clk;

  // Counts clear pulses and cuts a hang short.
  always @(posedge core_clk) begin
    cycles++;
    if (run_time_clear === 1'b1) n_clr++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Compares one observed value with its expectation.
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle register read, returning the data of the following cycle.
  task automatic rd(logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Moves the switches, then lets the levels and registered requests settle.
  task automatic setsw(logic [9:0] v);
    @(posedge core_clk);
    sw_want <= v;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : setsw

  // Packed outputs with every terminal OFF for a given config.
  function automatic logic [31:0] base(logic [15:0] c);
    logic [31:0] b;
    b = '0;
    b[16] = c[6];
    b[13] = c[7];
    b[4:3] = c[1:0];
    b[2:1] = c[3:2];
    return b;
  endfunction : base

  // Main sequence: reset, table, then the awkward cases.
  initial begin
    logic [15:0] d;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ADDR_CONFIG, d);
    chk("config reset", d, CONFIG_RESET);
    @(posedge core_clk);
    #1 chk("rdata idle", reg_rdata, 32'h0);
    rd(ADDR_FUNC_BASE, d);
    chk("selector reset", d, FUNC_RESET);
    rd(8'h7F, d);
    chk("unmapped read", d, 32'h0);
    chk("outputs idle", obs, 32'h0);
    foreach (rows[i]) begin
      wr(ADDR_FUNC_BASE + 8'(rows[i].idx), {10'h000, rows[i].fn});
      wr(ADDR_CONFIG, rows[i].cfg);
      setsw(10'h001 << rows[i].idx);
      chk("outputs on", obs, rows[i].exp);
      setsw(10'h000);
      chk("outputs off", obs, base(rows[i].cfg));
      wr(ADDR_FUNC_BASE + 8'(rows[i].idx), 16'h0000);
    end
    wr(ADDR_CONFIG, 16'h0000);
    wr(8'h00, 16'h0029);
    wr(8'h01, 16'h002A);
    setsw(10'h003);
    chk("motor four", motor_sel, 32'h3);
    rd(ADDR_STATUS, d);
    chk("status motor four", d, 32'h000C);
    rd(ADDR_LEVELS, d);
    chk("levels read", d, 32'h0003);
    setsw(10'h002);
    chk("motor three", motor_sel, 32'h2);
    wr(8'h00, 16'h0021);
    wr(8'h01, 16'h002C);
    setsw(10'h003);
    chk("fault both", fault_code, FAULT_EXTERNAL);
    rd(ADDR_STATUS, d);
    chk("status fault", d, {FAULT_EXTERNAL, 8'h00});
    setsw(10'h002);
    chk("fault user", fault_code, FAULT_USER_ONE);
    wr(8'h00, 16'h0031);
    wr(8'h01, 16'h0000);
    setsw(10'h001);
    chk("decel phase", {decel_to_brake_req, dc_brake_req}, 32'h2);
    @(posedge core_clk);
    at_brake_freq <= 1'b1;
    setsw(10'h001);
    chk("brake phase", {decel_to_brake_req, dc_brake_req}, 32'h1);
    @(posedge core_clk);
    at_brake_freq <= 1'b0;
    setsw(10'h000);
    wr(ADDR_CONFIG, 16'h0300);
    wr(8'h00, 16'h0032);
    n_clr = 0;
    setsw(10'h001);
    setsw(10'h001);
    chk("clear pulses", n_clr, 32'h1);
    setsw(10'h000);
    wr(ADDR_CONFIG, 16'h0100);
    n_clr = 0;
    setsw(10'h001);
    chk("clear blocked", n_clr, 32'h0);
    setsw(10'h000);
    // A write offered while the clock enable is low must be dropped.
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_CONFIG, 16'h00FF);
    clk_en <= 1'b1;
    rd(ADDR_CONFIG, d);
    chk("write while frozen", d, 32'h0100);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ADDR_CONFIG, d);
    chk("config second reset", d, CONFIG_RESET);
    conclude();
  end
endmodule : tb_digital_input_function_dispatcher
